/* vop_ctrl.sv */
// Purpose: offset selection, phase handling and fault protection
// Assumes: comparator inputs synchronous, APB slave with no wait states
// Notes:   latched faults clear only by reset or an enable rising edge
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// holds hit once cond has stayed high for N cycles
module vop_filt #(parameter int N = 4) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cond_i,
  output logic      hit_o
);
  localparam int W = $clog2(N + 1);
  localparam logic [W-1:0] TOP = W'(N);
  logic [W-1:0] cnt;
  // saturating run-length counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cnt <= '0;
    else if (!cond_i) cnt <= '0;
    else if (cnt != TOP) cnt <= cnt + 1'b1;
  end
  assign hit_o = (cnt == TOP);
endmodule

// How it works
// - sample offset pin low at enable rise
// - straps pick offset pin per rail
// - core offset is pin minus 1.2V plus initial
// - rising code forces four phases, falling holds
// - diode emulation swaps ramp, strap sets ramp
// - monitor voltage to 511 steps of 6.25mV
// - fast pulse overrides on-time of active phases
// - average trip needs trigger delay
// - peak trip acts at once
// - trip drives indicator low, starts action delay
// - still high after delay kills all drives
// - average threshold is percent of peak
// - overvoltage floor 0.9V+325mV or ref+325mV
// - overvoltage turns low sides on, highs off
// - overvoltage shuts down other rail too
// - overvoltage needs 1us persistence
// - negative output drops low sides during overvoltage
// - undervoltage after 3us turns all off
// - undervoltage shuts down other rail too
// - supply low 3us halts all drives
// - disabled second rail rejects its commands
module vop_ctrl
  import vop_pkg::*;
#(
  parameter int TRIG_CYC = 16,
  parameter int ACT_CYC  = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        enable_i,
  input  wire logic        primary_offset_low_i,
  input  wire logic [11:0] primary_offset_pin_i,
  input  wire logic [11:0] alternate_offset_pin_i,
  input  wire logic [1:0]  offset_enable_strap_i,
  input  wire logic [1:0]  ramp_amplitude_strap_i,
  input  wire logic [1:0]  ocp_pct_strap_i,
  input  wire logic        code_up_i,
  input  wire logic        code_down_i,
  input  wire logic [13:0] current_monitor_pin_i,
  input  wire logic        adc_sample_i,
  input  wire logic        fast_trigger_i,
  input  wire logic        avg_above_i,
  input  wire logic        peak_above_i,
  input  wire logic        filt_above_i,
  input  wire logic [9:0]  peak_threshold_i,
  input  wire logic [11:0] output_sense_input_i,
  input  wire logic [11:0] voltage_code_i,
  input  wire logic        sense_below_zero_i,
  input  wire logic        vcc_low_i,
  input  wire logic        driver_supply_monitor_low_i,
  input  wire logic        second_rail_fault_i,
  input  wire logic        second_rail_sense_neg_1_high_i,
  input  wire logic        second_rail_cmd_i,
  output logic [13:0]      core_offset_o,
  output logic [13:0]      second_rail_offset_o,
  output logic [2:0]       active_phases_o,
  output logic             diode_emulation_o,
  output logic [2:0]       ramp_setting_o,
  output logic             fast_transient_pulse_o,
  output logic [3:0]       ontime_override_o,
  output logic [9:0]       avg_threshold_o,
  output logic             overcurrent_indicator_n_o,
  output logic [3:0]       high_side_en_o,
  output logic [3:0]       low_side_en_o,
  output logic             second_rail_soft_off_o,
  output logic             core_soft_off_o,
  output logic             second_rail_cmd_accept_o,
  output logic             second_rail_cmd_reject_o
);
  logic [13:0] ctrl;
  logic [11:0] ton;
  logic [8:0]  iout;
  logic        en_q;
  logic        init_on;
  logic [11:0] qr_cnt;
  logic [15:0] act_cnt;
  vop_oc_t     oc_st;
  logic        overvoltage_latch;
  logic        undervoltage_latch;
  logic        avg_hit;
  logic        ov_hit;
  logic        uv_hit;
  logic        supply_lockout;

  // strap and control decode
  wire         en_rise   = enable_i & ~en_q;
  wire         core_str  = offset_enable_strap_i[1];
  wire         second_rail_offset_enable = offset_enable_strap_i[0];
  vop_sel_t    core_sel;
  vop_sel_t    nb_sel;
  assign core_sel = !core_str ? SEL_NONE :
                    second_rail_offset_enable ? SEL_PRI : SEL_ALT;
  assign nb_sel   = !second_rail_offset_enable ? SEL_NONE :
                    core_str ? SEL_ALT : SEL_PRI;

  // external offset is pin minus reference
  wire [13:0] pri_ext = {2'b00, primary_offset_pin_i} - {1'b0, OFS_REF_MV};
  wire [13:0] alt_ext = {2'b00, alternate_offset_pin_i} - {1'b0, OFS_REF_MV};
  wire [13:0] core_ext = core_sel == SEL_PRI ? pri_ext :
                         core_sel == SEL_ALT ? alt_ext : 14'h0000;
  wire [13:0] nb_ext   = nb_sel == SEL_PRI ? pri_ext :
                         nb_sel == SEL_ALT ? alt_ext : 14'h0000;
  wire [13:0] init_ofs = init_on ? {{4{ctrl[9]}}, ctrl[9:0]} : 14'h0000;

  // phase count and ramp selection
  wire [2:0] phase_req = ctrl[12:10];
  wire [2:0] next_phases = code_up_i ? ALL_PHASES :
                           code_down_i ? active_phases_o : phase_req;
  wire       next_dem = ctrl[13] & (phase_req == 3'h1) &
                        ~code_up_i & ~code_down_i;
  wire [2:0] next_ramp = next_dem ? RAMP_DEM
                                  : {1'b0, ramp_amplitude_strap_i};
  logic [3:0] act_mask;
  always_comb begin
    for (int i = 0; i < 4; i++) act_mask[i] = (3'(i) < active_phases_o);
  end

  // current monitor conversion with clamp
  wire [13:0] adc_q   = current_monitor_pin_i / ADC_LSB_Q;
  wire [8:0]  adc_val = (adc_q > {5'h00, ADC_MAX}) ? ADC_MAX : adc_q[8:0];

  // average threshold from strap percentage
  wire [16:0] thr_prod = peak_threshold_i * PCT_TAB[ocp_pct_strap_i];
  wire [16:0] thr_div  = thr_prod / PCT_DIV;

  // fault conditions
  wire [12:0] vsen  = {1'b0, output_sense_input_i};
  wire [12:0] vref  = {1'b0, voltage_code_i};
  wire ov_cond = (vref < OV_FLOOR_MV) ? (vsen > OV_FLOOR_MV + OV_UV_MV)
                                      : (vsen > vref + OV_UV_MV);
  wire uv_cond = (vsen + OV_UV_MV) < vref;
  wire oc_trip = avg_hit | peak_above_i;
  wire negative_voltage_guard     = overvoltage_latch & sense_below_zero_i;

  vop_filt #(.N(TRIG_CYC)) u_avg (.clk_i(clk_i), .rst_i(rst_i),
    .cond_i(avg_above_i), .hit_o(avg_hit));
  vop_filt #(.N(OV_FILT_CYC)) u_ov (.clk_i(clk_i), .rst_i(rst_i),
    .cond_i(ov_cond), .hit_o(ov_hit));
  vop_filt #(.N(UV_FILT_CYC)) u_uv (.clk_i(clk_i), .rst_i(rst_i),
    .cond_i(uv_cond), .hit_o(uv_hit));
  vop_filt #(.N(SUPPLY_LOCKOUT_CYC)) u_supply_lockout (.clk_i(clk_i), .rst_i(rst_i),
    .cond_i(vcc_low_i | driver_supply_monitor_low_i),
    .hit_o(supply_lockout));

  // drive enables after protection override
  wire all_off  = supply_lockout | undervoltage_latch | (oc_st == OC_OFF) |
                  ~enable_i;
  wire [3:0] next_hs = (all_off | overvoltage_latch) ? 4'h0 : act_mask;
  wire [3:0] next_ls = all_off ? 4'h0 :
                       overvoltage_latch ? (negative_voltage_guard ? 4'h0 : act_mask)
                                         : act_mask;

  // bus decode
  wire setup   = psel_i & ~penable_i;
  wire wr_en   = psel_i & penable_i & pwrite_i & pready_o;
  wire hit_ctl = paddr_i == CTRL_OFS;
  wire hit_ton = paddr_i == TON_OFS;
  wire hit_st  = paddr_i == STAT_OFS;
  wire hit_io  = paddr_i == IOUT_OFS;
  wire mapped  = hit_ctl | hit_ton | hit_st | hit_io;
  wire [31:0] stat_word = {23'h00_0000, second_rail_sense_neg_1_high_i,
                           core_soft_off_o, supply_lockout, oc_st == OC_OFF,
                           ~overcurrent_indicator_n_o, negative_voltage_guard,
                           undervoltage_latch, overvoltage_latch, init_on};
  wire [31:0] rd_word = hit_ctl ? {18'h0, ctrl} :
                        hit_ton ? {20'h0, ton} :
                        hit_st  ? stat_word :
                        hit_io  ? {23'h0, iout} : 32'h0000_0000;

  // apb: answer in the first access cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~mapped;
      prdata_o  <= (setup & ~pwrite_i) ? rd_word : 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      ton  <= TON_RST;
    end else if (wr_en) begin
      if (hit_ctl) ctrl <= pwdata_i[13:0];
      if (hit_ton) ton <= pwdata_i[11:0];
    end
  end

  // enable edge, offset sampling and offsets
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q                 <= 1'b0;
      init_on              <= 1'b0;
      core_offset_o        <= 14'h0000;
      second_rail_offset_o <= 14'h0000;
    end else begin
      en_q <= enable_i;
      if (en_rise) init_on <= ~primary_offset_low_i;
      core_offset_o        <= core_ext + init_ofs;
      second_rail_offset_o <= nb_ext;
    end
  end

  // phases, ramp, monitor result and threshold
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_phases_o   <= ALL_PHASES;
      diode_emulation_o <= 1'b0;
      ramp_setting_o    <= 3'h0;
      iout              <= 9'h000;
      avg_threshold_o   <= 10'h000;
    end else begin
      active_phases_o   <= next_phases;
      diode_emulation_o <= next_dem;
      ramp_setting_o    <= next_ramp;
      if (adc_sample_i) iout <= adc_val;
      avg_threshold_o   <= thr_div[9:0];
    end
  end

  // fast transient pulse, one on-time long
  wire [11:0] next_qr = (fast_trigger_i && qr_cnt == 12'h000) ? ton :
                        (qr_cnt != 12'h000) ? qr_cnt - 12'h001 : 12'h000;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      qr_cnt                 <= 12'h000;
      fast_transient_pulse_o <= 1'b0;
      ontime_override_o      <= 4'h0;
    end else begin
      qr_cnt                 <= next_qr;
      fast_transient_pulse_o <= next_qr != 12'h000;
      ontime_override_o      <= (next_qr != 12'h000) ? act_mask : 4'h0;
    end
  end

  // overcurrent: indicator, action delay, shutdown
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_st                     <= OC_IDLE;
      act_cnt                   <= 16'h0000;
      overcurrent_indicator_n_o <= 1'b1;
    end else if (en_rise) begin
      oc_st                     <= OC_IDLE;
      overcurrent_indicator_n_o <= 1'b1;
    end else begin
      case (oc_st)
        OC_IDLE: if (oc_trip) begin
          oc_st                     <= OC_WAIT;
          act_cnt                   <= 16'(ACT_CYC - 1);
          overcurrent_indicator_n_o <= 1'b0;
        end
        OC_WAIT: if (act_cnt != 16'h0000) begin
          act_cnt <= act_cnt - 16'h0001;
        end else if (filt_above_i) begin
          oc_st <= OC_OFF;
        end else begin
          oc_st                     <= OC_IDLE;
          overcurrent_indicator_n_o <= 1'b1;
        end
        default: oc_st <= OC_OFF;
      endcase
    end
  end

  // voltage fault latches and cross-rail shutdown
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overvoltage_latch      <= 1'b0;
      undervoltage_latch     <= 1'b0;
      second_rail_soft_off_o <= 1'b0;
      core_soft_off_o        <= 1'b0;
    end else begin
      if (en_rise) begin // a fault set below wins over this clear
        overvoltage_latch      <= 1'b0;
        undervoltage_latch     <= 1'b0;
        second_rail_soft_off_o <= 1'b0;
        core_soft_off_o        <= 1'b0;
      end
      if (ov_hit) overvoltage_latch <= 1'b1;
      if (uv_hit) undervoltage_latch <= 1'b1;
      if (ov_hit | uv_hit) second_rail_soft_off_o <= 1'b1;
      if (second_rail_fault_i) core_soft_off_o <= 1'b1;
    end
  end

  // drives and second rail command gate
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      high_side_en_o           <= 4'h0;
      low_side_en_o            <= 4'h0;
      second_rail_cmd_accept_o <= 1'b0;
      second_rail_cmd_reject_o <= 1'b0;
    end else begin
      high_side_en_o           <= next_hs;
      low_side_en_o            <= next_ls;
      second_rail_cmd_accept_o <= second_rail_cmd_i &
                                  ~second_rail_sense_neg_1_high_i;
      second_rail_cmd_reject_o <= second_rail_cmd_i &
                                  second_rail_sense_neg_1_high_i;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ov_steady;
    ov_hit && !en_rise;
  endsequence
  sequence s_oc_start;
    oc_st == OC_IDLE && oc_trip && !en_rise;
  endsequence

  a_offset_sample: assert property (en_rise |=> init_on == !$past(primary_offset_low_i))
    else $error("offset pin sample wrong");
  a_phase_up_all: assert property (code_up_i |=> active_phases_o == ALL_PHASES)
    else $error("rising code did not force all phases");
  a_phase_down_hold: assert property (code_down_i |=> $stable(active_phases_o))
    else $error("falling code changed phases");
  a_dem_ramp: assert property (diode_emulation_o |-> ramp_setting_o == RAMP_DEM)
    else $error("ramp not modified in diode emulation");
  a_adc_range: assert property (adc_sample_i && current_monitor_pin_i == 14'h0019 |=> iout == 9'h001)
    else $error("monitor step not 6.25mV");
  a_qr_width: assert property ($rose(fast_transient_pulse_o) |-> qr_cnt == ton)
    else $error("fast pulse length wrong");
  a_peak_ind: assert property (s_oc_start |=> !overcurrent_indicator_n_o ##0 oc_st == OC_WAIT)
    else $error("trip did not raise indicator");
  a_oc_off: assert property (oc_st == OC_OFF |=> high_side_en_o == 4'h0 && low_side_en_o == 4'h0)
    else $error("drives alive after overcurrent off");
  a_ov_filter: assert property ($rose(overvoltage_latch) |-> $past(ov_hit))
    else $error("overvoltage latched without filter");
  a_ov_drive: assert property (s_ov_steady |=> overvoltage_latch)
    else $error("overvoltage not latched in time");
  a_nvp_low: assert property (overvoltage_latch && sense_below_zero_i && !en_rise |=> low_side_en_o == 4'h0 && high_side_en_o == 4'h0)
    else $error("low sides on with negative output");
  a_supply_lockout_off: assert property (supply_lockout |=> high_side_en_o == 4'h0 && low_side_en_o == 4'h0)
    else $error("drives alive in supply lockout");
  a_nb_reject: assert property (second_rail_cmd_i && second_rail_sense_neg_1_high_i |=> second_rail_cmd_reject_o && !second_rail_cmd_accept_o)
    else $error("disabled rail accepted command");
  a_latch_hold: assert property (overvoltage_latch && !en_rise |=> overvoltage_latch)
    else $error("overvoltage latch dropped");
endmodule

`default_nettype wire

/* vop_pkg.sv */
// Purpose: shared constants for the rail offset and protection block
// Assumes: 125 MHz clock, analog levels arrive as codes or comparator bits
// Notes:   voltages in mV unless named otherwise
package vop_pkg;
  localparam int CLK_MHZ      = 125;
  // protection filter times
  localparam int OV_FILT_NS   = 1000;
  localparam int UV_FILT_NS   = 3000;
  localparam int SUPPLY_LOCKOUT_FILT_NS = 3000;
  localparam int OV_FILT_CYC  = (OV_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_FILT_CYC  = (UV_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int SUPPLY_LOCKOUT_CYC     = (SUPPLY_LOCKOUT_FILT_NS * CLK_MHZ + 999) / 1000;
  // voltage thresholds
  localparam logic [12:0] OFS_REF_MV  = 13'h04B0; // 1200 mV
  localparam logic [12:0] OV_FLOOR_MV = 13'h0384; // 900 mV
  localparam logic [12:0] OV_UV_MV    = 13'h0145; // 325 mV
  // current monitor conversion, input in 0.25 mV steps
  localparam logic [13:0] ADC_LSB_Q   = 14'h0019; // 6.25 mV
  localparam logic [8:0]  ADC_MAX     = 9'h1FF;   // 511
  // average trip as percent of spike trip, per strap
  localparam logic [6:0]  PCT_TAB [4] = '{7'h64, 7'h5A, 7'h50, 7'h46};
  localparam logic [16:0] PCT_DIV     = 17'h0064;
  localparam logic [2:0]  ALL_PHASES  = 3'h4;
  localparam logic [2:0]  RAMP_DEM    = 3'h4;
  // register map, byte addresses
  localparam logic [7:0]  CTRL_OFS = 8'h00;
  localparam logic [7:0]  TON_OFS  = 8'h04;
  localparam logic [7:0]  STAT_OFS = 8'h08;
  localparam logic [7:0]  IOUT_OFS = 8'h0C;
  localparam logic [13:0] CTRL_RST = 14'h1000; // four phases, no offset
  localparam logic [11:0] TON_RST  = 12'h0040;
  typedef enum logic [1:0] {SEL_NONE, SEL_PRI, SEL_ALT} vop_sel_t;
  typedef enum {OC_IDLE, OC_WAIT, OC_OFF} vop_oc_t;
endpackage

/* vop_cpu_model.sv */
// Purpose: far-side model, voltage-code master and rail strap
// Assumes: requests change just after a rising edge
// Notes:   rail disable is a board level, not a pulse
`timescale 1ns/1ps
`default_nettype none
module vop_cpu_model (
  input  wire logic clk_i,
  output logic      code_up_o,
  output logic      code_down_o,
  output logic      cmd_o,
  output logic      rail_off_o
);
  // quiet until asked
  initial begin
    {code_up_o, code_down_o, cmd_o, rail_off_o} = 4'h0;
  end
  // transition levels, held until changed
  task automatic set_code(input logic up, input logic dn);
    code_up_o   <= up;
    code_down_o <= dn;
  endtask
  // one-cycle command for the second rail
  task automatic send_cmd();
    cmd_o <= 1'b1;
    @(posedge clk_i);
    cmd_o <= 1'b0;
  endtask
  // board tie that disables the second rail
  task automatic rail_off(input logic v);
    rail_off_o <= v;
  endtask
endmodule
`default_nettype wire

/* vop_ctrl_bench.sv */
// Purpose: self-checking bench for the offset and protection block
// Assumes: trigger and action delays shortened to 4 cycles
// Notes:   xorshift stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module vop_ctrl_bench;
  import vop_pkg::*;
  localparam int          DLY = 4;
  localparam logic [11:0] OV_CODE [5] = '{12'h320, 12'h3e8, 12'h3e8, 12'h3e8, 12'h320};
  localparam logic [11:0] OV_SNS [5] = '{12'h4c9, 12'h52d, 12'h52e, 12'h52e, 12'h4ca};
  localparam int          OV_HOLD [5] = '{130, 130, OV_FILT_CYC - 3, OV_FILT_CYC + 5, 130};
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, enable_i, primary_offset_low_i;
  logic        adc_sample_i, fast_trigger_i, avg_above_i, peak_above_i, filt_above_i;
  logic        sense_below_zero_i, vcc_low_i, driver_supply_monitor_low_i, second_rail_fault_i;
  logic        code_up_i, code_down_i, second_rail_sense_neg_1_high_i, second_rail_cmd_i;
  logic        pready_o, pslverr_o, diode_emulation_o, fast_transient_pulse_o, pe;
  logic        overcurrent_indicator_n_o, second_rail_soft_off_o, core_soft_off_o;
  logic        second_rail_cmd_accept_o, second_rail_cmd_reject_o;
  logic [1:0]  offset_enable_strap_i, ramp_amplitude_strap_i, ocp_pct_strap_i;
  logic [2:0]  active_phases_o, ramp_setting_o;
  logic [3:0]  ontime_override_o, high_side_en_o, low_side_en_o;
  logic [7:0]  paddr_i;
  logic [9:0]  peak_threshold_i, avg_threshold_o;
  logic [11:0] primary_offset_pin_i, alternate_offset_pin_i, output_sense_input_i, voltage_code_i;
  logic [13:0] current_monitor_pin_i, core_offset_o, second_rail_offset_o;
  logic [31:0] pwdata_i, prdata_o, rd, a, b;
  logic [31:0] seed = 32'hab72;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          i, n;

  vop_ctrl #(.TRIG_CYC(DLY), .ACT_CYC(DLY)) u_vop_ctrl (
    .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .enable_i, .primary_offset_low_i, .primary_offset_pin_i, .alternate_offset_pin_i,
    .offset_enable_strap_i, .ramp_amplitude_strap_i, .ocp_pct_strap_i, .code_up_i, .code_down_i,
    .current_monitor_pin_i, .adc_sample_i, .fast_trigger_i, .avg_above_i, .peak_above_i,
    .filt_above_i, .peak_threshold_i, .output_sense_input_i, .voltage_code_i, .sense_below_zero_i,
    .vcc_low_i, .driver_supply_monitor_low_i, .second_rail_fault_i, .second_rail_sense_neg_1_high_i,
    .second_rail_cmd_i, .core_offset_o, .second_rail_offset_o, .active_phases_o, .diode_emulation_o,
    .ramp_setting_o, .fast_transient_pulse_o, .ontime_override_o, .avg_threshold_o,
    .overcurrent_indicator_n_o, .high_side_en_o, .low_side_en_o, .second_rail_soft_off_o,
    .core_soft_off_o, .second_rail_cmd_accept_o, .second_rail_cmd_reject_o
  );
  vop_cpu_model u_vop_cpu_model (.clk_i, .code_up_o(code_up_i), .code_down_o(code_down_i),
    .cmd_o(second_rail_cmd_i), .rail_off_o(second_rail_sense_neg_1_high_i));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // monitor code: whole steps, clamped at full scale
  function automatic logic [31:0] iout(input logic [31:0] q);
    return (q / ADC_LSB_Q > ADC_MAX) ? 32'(ADC_MAX) : q / ADC_LSB_Q;
  endfunction
  // external offset: pin level minus the reference
  function automatic logic [13:0] ofs(input logic [31:0] v);
    return 14'(v) - 14'(OFS_REF_MV);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // one apb transfer, idle cycle after it
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k = 0;
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, ad, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1);
    chk("pready", k, 1);
    rd = prdata_o;
    pe = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  // enable low then high, clears latched faults
  task automatic en_cycle();
    enable_i <= 1'b0;
    cy(3);
    enable_i <= 1'b1;
    cy(4);
  endtask

  // main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, enable_i, primary_offset_low_i, adc_sample_i, fast_trigger_i,
     avg_above_i, peak_above_i, filt_above_i, sense_below_zero_i, vcc_low_i, second_rail_fault_i,
     driver_supply_monitor_low_i, offset_enable_strap_i, ramp_amplitude_strap_i, ocp_pct_strap_i,
     paddr_i, pwdata_i, current_monitor_pin_i, peak_threshold_i} = '0;
    {primary_offset_pin_i, alternate_offset_pin_i} = {2{12'h4b0}};
    {output_sense_input_i, voltage_code_i} = {2{12'h3e8}};
    rst_i = 1'b1;
    cy(3);
    rst_i <= 1'b0;
    // register defaults, refused address, read-only place
    apb(0, CTRL_OFS, 0);
    chk("ctrl_rst", rd, 32'(CTRL_RST));
    apb(0, TON_OFS, 0);
    chk("ton_rst", rd, 32'(TON_RST));
    apb(0, 8'h10, 0);
    chk("unmapped", {pe, rd[30:0]}, 32'h8000_0000);
    apb(1, IOUT_OFS, 32'h0000_01ff);
    apb(0, IOUT_OFS, 0);
    chk("iout_ro", rd, 0);
    apb(1, TON_OFS, 32'h0000_000a);
    en_cycle();
    // quick pulse length and phase override
    fast_trigger_i <= 1'b1;
    cy(1);
    fast_trigger_i <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge clk_i);
      if (fast_transient_pulse_o === 1'b1) begin
        chk("override", ontime_override_o, 4'hf);
        n++;
      end
    end
    chk("pulse_len", n, 10);
    // phase count across code steps
    apb(1, CTRL_OFS, 32'h0000_0800);
    for (i = 0; i < 4; i++) begin
      u_vop_cpu_model.set_code(i == 1, i == 2);
      cy(3);
      chk("phases", active_phases_o, (i == 0 || i == 3) ? 3'h2 : ALL_PHASES);
    end
    // ramp per strap and mode, monitor code, average threshold
    for (i = 0; i < 8; i++) begin
      a = (i < 3) ? 32'(ADC_MAX) * ADC_LSB_Q + 32'(i) - 1 : (i == 3) ? 32'h0000_0019 : rnd() % 32'h3200;
      b = rnd();
      {current_monitor_pin_i, peak_threshold_i} <= {a[13:0], b[9:0]};
      {ocp_pct_strap_i, ramp_amplitude_strap_i} <= {2{i[1:0]}};
      adc_sample_i <= 1'b1;
      apb(1, CTRL_OFS, {18'h0, i[2], 13'h0400});
      adc_sample_i <= 1'b0;
      cy(2);
      chk("dem", diode_emulation_o, i[2]);
      chk("ramp", ramp_setting_o, i[2] ? RAMP_DEM : {1'b0, i[1:0]});
      chk("avg_thr", avg_threshold_o, b[9:0] * PCT_TAB[i[1:0]] / PCT_DIV);
      apb(0, IOUT_OFS, 0);
      chk("iout", rd, iout(a));
    end
    apb(1, CTRL_OFS, 32'(CTRL_RST));
    // offset source per strap pair
    for (i = 0; i < 4; i++) begin
      a = 32'd300 + rnd() % 2100;
      b = 32'd300 + rnd() % 2100;
      {primary_offset_pin_i, alternate_offset_pin_i} <= {a[11:0], b[11:0]};
      offset_enable_strap_i <= i[1:0];
      en_cycle();
      chk("core_ofs", core_offset_o, i[1] ? ofs(i[0] ? a : b) : 14'h0);
      chk("rail_ofs", second_rail_offset_o, i[0] ? ofs(i[1] ? b : a) : 14'h0);
    end
    // initial offset kept or dropped at enable rise
    offset_enable_strap_i <= 2'b00;
    apb(1, CTRL_OFS, 32'h0000_1032);
    for (i = 0; i < 2; i++) begin
      primary_offset_low_i <= i[0];
      en_cycle();
      chk("init_ofs", core_offset_o, i[0] ? 14'h0 : 14'h0032);
    end
    primary_offset_low_i <= 1'b0;
    cy(3);
    chk("init_held", core_offset_o, 14'h0);
    apb(1, CTRL_OFS, 32'(CTRL_RST));
    // overcurrent: short excess, average trip, peak trip
    en_cycle();
    avg_above_i <= 1'b1;
    cy(DLY - 1);
    avg_above_i <= 1'b0;
    cy(4);
    chk("oc_short", overcurrent_indicator_n_o, 1'b1);
    avg_above_i <= 1'b1;
    cy(7);
    chk("oc_avg", overcurrent_indicator_n_o, 1'b0);
    avg_above_i <= 1'b0;
    cy(DLY + 4);
    chk("oc_release", overcurrent_indicator_n_o, 1'b1);
    {peak_above_i, filt_above_i} <= 2'b11;
    cy(1);
    peak_above_i <= 1'b0;
    cy(2);
    chk("oc_peak", overcurrent_indicator_n_o, 1'b0);
    cy(DLY + 3);
    chk("oc_off", {high_side_en_o, low_side_en_o}, 8'h00);
    apb(0, STAT_OFS, 0);
    chk("oc_stat", rd[5], 1'b1);
    filt_above_i <= 1'b0;
    // overvoltage levels, floor case and filter time
    for (i = 0; i < 5; i++) begin
      {voltage_code_i, output_sense_input_i} <= {2{OV_CODE[i]}};
      en_cycle();
      output_sense_input_i <= OV_SNS[i];
      cy(OV_HOLD[i]);
      output_sense_input_i <= OV_CODE[i];
      cy(3);
      apb(0, STAT_OFS, 0);
      chk("ov_latch", rd[1], i > 2);
    end
    chk("ov_drive", {high_side_en_o, low_side_en_o}, 8'h0f);
    chk("ov_other", second_rail_soft_off_o, 1'b1);
    sense_below_zero_i <= 1'b1;
    cy(3);
    chk("nv_drive", {high_side_en_o, low_side_en_o}, 8'h00);
    sense_below_zero_i <= 1'b0;
    cy(3);
    chk("nv_back", {high_side_en_o, low_side_en_o}, 8'h0f);
    en_cycle();
    apb(0, STAT_OFS, 0);
    chk("ov_clear", rd[1], 1'b0);
    // undervoltage, then fault of the other rail
    output_sense_input_i <= 12'h190;
    cy(UV_FILT_CYC + 5);
    apb(0, STAT_OFS, 0);
    chk("uv_latch", rd[2], 1'b1);
    chk("uv_drive", {high_side_en_o, low_side_en_o}, 8'h00);
    chk("uv_other", second_rail_soft_off_o, 1'b1);
    output_sense_input_i <= OV_CODE[4];
    en_cycle();
    second_rail_fault_i <= 1'b1;
    cy(1);
    second_rail_fault_i <= 1'b0;
    cy(3);
    chk("core_soft", core_soft_off_o, 1'b1);
    // supply lockout from either monitor
    for (i = 0; i < 2; i++) begin
      en_cycle();
      {vcc_low_i, driver_supply_monitor_low_i} <= i[0] ? 2'b01 : 2'b10;
      cy(SUPPLY_LOCKOUT_CYC + 5);
      apb(0, STAT_OFS, 0);
      chk("lockout", rd[6], 1'b1);
      chk("lock_drive", {high_side_en_o, low_side_en_o}, 8'h00);
      {vcc_low_i, driver_supply_monitor_low_i} <= 2'b00;
      cy(3);
      apb(0, STAT_OFS, 0);
      chk("unlock", rd[6], 1'b0);
    end
    // second rail commands, enabled then disabled
    for (i = 0; i < 2; i++) begin
      u_vop_cpu_model.rail_off(i[0]);
      cy(2);
      u_vop_cpu_model.send_cmd();
      cy(1);
      chk("accept", second_rail_cmd_accept_o, !i[0]);
      chk("reject", second_rail_cmd_reject_o, i[0]);
    end
    test_done();
  end
endmodule
`default_nettype wire
